/* File: logic/rcfm_pkg.sv */
// Constants, field layouts and types of the resolver conversion fault monitor
// Notes on behaviour
// - Circuit select 0 picks high-speed epsilon detector
// - Judge-time field 11b gives a 7.37 ms window
// - Arm bit masks faults 26 ms, then enables
// - Clear write resets each status flag whose fault has gone
// - Flag stays set if its fault persists
// - Conv route 0 sets summary, held, flag, detail
// - Mode 0 compares mode-0 and mode-1 angles
// - Threshold field value 2 means +-32 LSB
// - Threshold field used only in mode 0
// - Mode 1 compares twin circuits at +-1 LSB
// - Dual route 0 sets summary, held, flag, detail
// - Supply and ground shorts checked on six lines
// - Excitation and common checks only with external excitation
// - Switch opens, lines tested 13 us each
// - Monitor outputs sit at common while open
// - Angle advances at captured speed while open
// - Half-period abnormal above 50% out-of-range
// - Window fault when abnormal halves exceed 50%
// - Software start bit runs one short sequence
`default_nettype none
package rcfm_pkg;
  // Clock and timing
  localparam int CLK_MHZ       = 250;
  localparam int CLK_PERIOD_PS = 1000000 / CLK_MHZ;
  localparam int ARM_MS        = 26;
  localparam int ARM_CYC       = ARM_MS * 1000 * CLK_MHZ;
  localparam int JUDGE0_US     = 920;
  localparam int JUDGE1_US     = 1840;
  localparam int JUDGE2_US     = 3680;
  localparam int JUDGE3_US     = 7370;
  localparam int JUDGE0_CYC    = JUDGE0_US * CLK_MHZ;
  localparam int JUDGE1_CYC    = JUDGE1_US * CLK_MHZ;
  localparam int JUDGE2_CYC    = JUDGE2_US * CLK_MHZ;
  localparam int JUDGE3_CYC    = JUDGE3_US * CLK_MHZ;
  localparam int SLOT_NS       = 13000;
  localparam int SLOT_CYC      = SLOT_NS * 1000 / CLK_PERIOD_PS;
  localparam int NUM_LINES     = 6;
  // Dual path thresholds in LSB per field code
  localparam int DP_THR0       = 8;
  localparam int DP_THR1       = 16;
  localparam int DP_THR2       = 32;
  localparam int DP_THR3       = 64;
  localparam int MODE1_THR     = 1;
  // Register byte offsets
  localparam int ADDR_W        = 8;
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  // Configuration fields
  localparam int CF_CVSEL      = 0;
  localparam int CF_JUDGE      = 1;
  localparam int CF_CVROUTE    = 3;
  localparam int CF_MODE       = 4;
  localparam int CF_THR        = 5;
  localparam int CF_DPROUTE    = 7;
  localparam int CF_EXSRC      = 8;
  localparam int CF_TRIG       = 9;
  localparam int CF_W          = 11;
  localparam logic [10:0] CFG_RST = 11'h000;
  localparam logic [1:0] TRIG_SW  = 2'h1;
  // Control fields
  localparam int CT_ARM        = 0;
  localparam int CT_CLR        = 1;
  localparam int CT_START      = 2;
  // Status fields
  localparam int ST_SUM        = 0;
  localparam int ST_HELD       = 1;
  localparam int ST_CONV       = 2;
  localparam int ST_CONV_DET   = 3;
  localparam int ST_DUAL       = 4;
  localparam int ST_DUAL_DET   = 5;
  localparam int ST_PWR        = 6;
  localparam int ST_GND        = 12;
  localparam int ST_W          = 18;
  // Short test sequencer states
  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_TEST = 2'b01,
    SEQ_DONE = 2'b11
  } rcfm_seq_e;
endpackage
`default_nettype wire

/* File: logic/rcfm_short_if.sv */
// Interface between fault monitor and short test sequencer
`timescale 1ns/1ps
`default_nettype none
interface rcfm_short_if;
  logic       start;
  logic       busy;
  logic       done;
  logic       sw_open;
  logic [2:0] line;
  logic [5:0] pwr;
  logic [5:0] gnd;
  modport ctl (output start, input busy, done, sw_open, line, pwr, gnd);
  modport seq (input start, output busy, done, sw_open, line, pwr, gnd);
endinterface
`default_nettype wire

/* File: logic/rcfm_short_seq.sv */
// Sequencer that opens the input switch and tests six lines in turn
`timescale 1ns/1ps
`default_nettype none
module rcfm_short_seq
(
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_b_i,
  rcfm_short_if.seq                        sh,
  input  wire logic [rcfm_pkg::NUM_LINES-1:0] line_hi_i,
  input  wire logic [rcfm_pkg::NUM_LINES-1:0] line_lo_i
);
  import rcfm_pkg::*;

  rcfm_seq_e  state;
  logic [11:0] slot_cnt;

  assign sh.busy = (state != SEQ_IDLE);

  // Walk the lines, one slot each, with the switch open
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state      <= SEQ_IDLE;
      slot_cnt   <= 12'h000;
      sh.line    <= 3'h0;
      sh.sw_open <= 1'b0;
      sh.done    <= 1'b0;
      sh.pwr     <= 6'h00;
      sh.gnd     <= 6'h00;
    end
    else
    begin
      sh.done <= 1'b0;
      case (state)
        SEQ_IDLE:
        begin
          if (sh.start)
          begin
            state      <= SEQ_TEST;
            slot_cnt   <= 12'h000;
            sh.line    <= 3'h0;
            sh.sw_open <= 1'b1;
            sh.pwr     <= 6'h00;
            sh.gnd     <= 6'h00;
          end
        end
        SEQ_TEST:
        begin
          if (slot_cnt == 12'(SLOT_CYC - 1))
          begin
            slot_cnt            <= 12'h000;
            sh.pwr[sh.line]     <= line_hi_i[sh.line];
            sh.gnd[sh.line]     <= line_lo_i[sh.line];
            if (sh.line == 3'(NUM_LINES - 1))
            begin
              state      <= SEQ_DONE;
              sh.sw_open <= 1'b0;
            end
            else
            begin
              sh.line <= sh.line + 3'h1;
            end
          end
          else
          begin
            slot_cnt <= slot_cnt + 12'h001;
          end
        end
        SEQ_DONE:
        begin
          state   <= SEQ_IDLE;
          sh.done <= 1'b1;
        end
        default:
        begin
          state <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Each line change comes after a full slot
  slot_length_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    ($changed(sh.line) && $past(sh.sw_open)) |-> $past(slot_cnt) == 12'(SLOT_CYC - 1))
    else $error("short test slot length wrong");

  seq_done_c: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) sh.done);
endmodule
`default_nettype wire

/* File: logic/rcfm_monitor_top.sv */
// Resolver conversion fault monitor with Avalon-MM register slave
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module rcfm_monitor_top
#(
  parameter int ANGLE_W    = 16,
  parameter int ARM_CYCLES = rcfm_pkg::ARM_CYC,
  parameter int JUDGE_CYC0 = rcfm_pkg::JUDGE0_CYC,
  parameter int JUDGE_CYC1 = rcfm_pkg::JUDGE1_CYC,
  parameter int JUDGE_CYC2 = rcfm_pkg::JUDGE2_CYC,
  parameter int JUDGE_CYC3 = rcfm_pkg::JUDGE3_CYC
)
(
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_b_i,
  input  wire logic [rcfm_pkg::ADDR_W-1:0]    avs_address_i,
  input  wire logic                           avs_read_i,
  input  wire logic                           avs_write_i,
  input  wire logic [31:0]                    avs_writedata_i,
  input  wire logic [3:0]                     avs_byteenable_i,
  output logic      [31:0]                    avs_readdata_o,
  output logic                                avs_waitrequest_o,
  input  wire logic                           epsilon_out_of_range_hs_i,
  input  wire logic                           epsilon_out_of_range_std_i,
  input  wire logic                           exc_half_tick_i,
  input  wire logic [ANGLE_W-1:0]             angle_mode0_i,
  input  wire logic [ANGLE_W-1:0]             angle_mode1_a_i,
  input  wire logic [ANGLE_W-1:0]             angle_mode1_b_i,
  input  wire logic [ANGLE_W-1:0]             speed_i,
  input  wire logic [rcfm_pkg::NUM_LINES-1:0] line_at_supply_i,
  input  wire logic [rcfm_pkg::NUM_LINES-1:0] line_at_ground_i,
  output logic                                err_summary_o,
  output logic                                held_fault_o,
  output logic                                switch_open_o,
  output logic                                monitor_at_common_o,
  output logic                                short_test_busy_o,
  output logic      [ANGLE_W-1:0]             angle_o
);
  import rcfm_pkg::*;

  rcfm_short_if sh ();

  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic [CF_W-1:0]      cfg;
  logic                 arm;
  logic                 mask_released;
  logic [23:0]          arm_cnt;
  logic                 wr_done;
  logic                 wr_cfg;
  logic                 wr_ctrl;
  logic                 clr_w;
  logic                 start_w;
  logic                 eps;
  logic [15:0]          hp_cyc;
  logic [15:0]          hp_hi;
  logic [23:0]          win_cyc;
  logic [23:0]          win_lim;
  logic                 win_end;
  logic [15:0]          half_tot;
  logic [15:0]          half_abn;
  logic                 conv_cond_q;
  logic                 conv_evt_q;
  logic [ANGLE_W-1:0]   path_a;
  logic [ANGLE_W-1:0]   path_b;
  logic [ANGLE_W-1:0]   diff;
  logic [ANGLE_W-1:0]   abs_diff;
  logic [ANGLE_W-1:0]   thr;
  logic                 dual_raw_q;
  logic [5:0]           hi_m;
  logic [5:0]           hi_s;
  logic [5:0]           lo_m;
  logic [5:0]           lo_s;
  logic [5:0]           line_mask;
  logic [11:0]          short_cond_q;
  logic                 short_evt_q;
  logic [ST_W-1:0]      err_q;
  logic [ST_W-1:0]      set_vec;
  logic [ST_W-1:0]      cond_vec;
  logic [ANGLE_W-1:0]   speed_hold;
  logic [ANGLE_W-1:0]   angle_q;
  logic                 monitor_q;
  logic                 sw_q;

  // Bus handshake: a request completes one cycle after it is presented
  assign wr_done = avs_write_i && !wait_q;
  assign wr_cfg  = wr_done && (avs_address_i == REG_CFG);
  assign wr_ctrl = wr_done && (avs_address_i == REG_CTRL) && avs_byteenable_i[0];
  assign clr_w   = wr_ctrl && avs_writedata_i[CT_CLR];
  assign start_w = wr_ctrl && avs_writedata_i[CT_START];

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wait_q <= 1'b1;
    else
      wait_q <= !((avs_read_i || avs_write_i) && wait_q);
  end

  // Read data captured while waitrequest is high; unmapped reads return zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_q <= 32'h0000_0000;
    else if (avs_read_i && wait_q)
    begin
      if (avs_address_i == REG_CFG)
        rdata_q <= 32'(cfg);
      else if (avs_address_i == REG_CTRL)
        rdata_q <= {29'h0, sh.busy, mask_released, arm};
      else if (avs_address_i == REG_STAT)
        rdata_q <= 32'(err_q);
      else
        rdata_q <= 32'h0000_0000;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // Configuration register, two byte lanes
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cfg <= CFG_RST;
    else if (wr_cfg)
    begin
      if (avs_byteenable_i[0])
        cfg[7:0] <= avs_writedata_i[7:0];
      if (avs_byteenable_i[1])
        cfg[10:8] <= avs_writedata_i[10:8];
    end
  end

  // Arm bit and its mask timer
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      arm           <= 1'b0;
      arm_cnt       <= 24'h000000;
      mask_released <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        arm <= avs_writedata_i[CT_ARM];
      if (!arm)
      begin
        arm_cnt       <= 24'h000000;
        mask_released <= 1'b0;
      end
      else if (arm_cnt != 24'(ARM_CYCLES - 1))
        arm_cnt <= arm_cnt + 24'h000001;
      else
        mask_released <= 1'b1;
    end
  end

  // Epsilon source choice
  assign eps = cfg[CF_CVSEL] ? epsilon_out_of_range_std_i : epsilon_out_of_range_hs_i;

  // Window length per judge-time code
  always_comb
  begin
    case (cfg[CF_JUDGE +: 2])
      2'h0:    win_lim = 24'(JUDGE_CYC0);
      2'h1:    win_lim = 24'(JUDGE_CYC1);
      2'h2:    win_lim = 24'(JUDGE_CYC2);
      default: win_lim = 24'(JUDGE_CYC3);
    endcase
  end

  assign win_end = (win_cyc >= win_lim - 24'h000001);

  // Half-period duty count and window aggregation
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hp_cyc      <= 16'h0000;
      hp_hi       <= 16'h0000;
      win_cyc     <= 24'h000000;
      half_tot    <= 16'h0000;
      half_abn    <= 16'h0000;
      conv_cond_q <= 1'b0;
      conv_evt_q  <= 1'b0;
    end
    else
    begin
      conv_evt_q <= 1'b0;
      if (exc_half_tick_i)
      begin
        hp_cyc <= 16'h0000;
        hp_hi  <= 16'h0000;
      end
      else
      begin
        hp_cyc <= hp_cyc + 16'h0001;
        hp_hi  <= hp_hi + {15'h0000, eps};
      end
      if (win_end)
      begin
        win_cyc     <= 24'h000000;
        half_tot    <= 16'h0000;
        half_abn    <= 16'h0000;
        conv_cond_q <= {half_abn, 1'b0} > {1'b0, half_tot};
        conv_evt_q  <= ({half_abn, 1'b0} > {1'b0, half_tot}) && mask_released;
      end
      else
      begin
        win_cyc <= win_cyc + 24'h000001;
        if (exc_half_tick_i)
        begin
          half_tot <= half_tot + 16'h0001;
          if ({hp_hi, 1'b0} > {1'b0, hp_cyc})
            half_abn <= half_abn + 16'h0001;
        end
      end
    end
  end

  // Dual path comparison, wrap-safe difference
  assign path_a   = cfg[CF_MODE] ? angle_mode1_a_i : angle_mode0_i;
  assign path_b   = cfg[CF_MODE] ? angle_mode1_b_i : angle_mode1_a_i;
  assign diff     = path_a - path_b;
  assign abs_diff = diff[ANGLE_W-1] ? (~diff + 1'b1) : diff;

  // Threshold: field in mode 0, fixed one LSB in mode 1
  always_comb
  begin
    if (cfg[CF_MODE])
      thr = ANGLE_W'(MODE1_THR);
    else
    begin
      case (cfg[CF_THR +: 2])
        2'h0:    thr = ANGLE_W'(DP_THR0);
        2'h1:    thr = ANGLE_W'(DP_THR1);
        2'h2:    thr = ANGLE_W'(DP_THR2);
        default: thr = ANGLE_W'(DP_THR3);
      endcase
    end
  end

  // Registered comparator result
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      dual_raw_q <= 1'b0;
    else
      dual_raw_q <= abs_diff > thr;
  end

  // Two-flop synchronisers for the line comparators
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hi_m <= 6'h00;
      hi_s <= 6'h00;
      lo_m <= 6'h00;
      lo_s <= 6'h00;
    end
    else
    begin
      hi_m <= line_at_supply_i;
      hi_s <= hi_m;
      lo_m <= line_at_ground_i;
      lo_s <= lo_m;
    end
  end

  assign sh.start  = start_w && (cfg[CF_TRIG +: 2] == TRIG_SW) && !sh.busy;
  assign line_mask = cfg[CF_EXSRC] ? 6'h3c : 6'h3f;

  rcfm_short_seq u_seq
  (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .sh        (sh),
    .line_hi_i (hi_s),
    .line_lo_i (lo_s)
  );

  // Short results held until the next sequence
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      short_cond_q <= 12'h000;
      short_evt_q  <= 1'b0;
    end
    else
    begin
      short_evt_q <= sh.done && mask_released;
      if (sh.done)
        short_cond_q <= {sh.gnd & line_mask, sh.pwr & line_mask};
    end
  end

  // Fault routing into set events and persisting conditions
  always_comb
  begin
    set_vec  = '0;
    cond_vec = '0;
    set_vec[ST_CONV_DET]  = conv_evt_q;
    cond_vec[ST_CONV_DET] = conv_cond_q && mask_released;
    if (!cfg[CF_CVROUTE])
    begin
      set_vec[ST_CONV]  = conv_evt_q;
      cond_vec[ST_CONV] = conv_cond_q && mask_released;
    end
    set_vec[ST_DUAL_DET]  = dual_raw_q && mask_released;
    cond_vec[ST_DUAL_DET] = dual_raw_q && mask_released;
    if (!cfg[CF_DPROUTE])
    begin
      set_vec[ST_DUAL]  = dual_raw_q && mask_released;
      cond_vec[ST_DUAL] = dual_raw_q && mask_released;
    end
    if (short_evt_q)
    begin
      set_vec[ST_PWR +: 6] = short_cond_q[5:0];
      set_vec[ST_GND +: 6] = short_cond_q[11:6];
      if ((short_cond_q[5:2] | short_cond_q[11:8]) != 4'h0)
        set_vec[ST_CONV] = 1'b1;
    end
    if (mask_released)
    begin
      cond_vec[ST_PWR +: 6] = short_cond_q[5:0];
      cond_vec[ST_GND +: 6] = short_cond_q[11:6];
      if ((short_cond_q[5:2] | short_cond_q[11:8]) != 4'h0)
        cond_vec[ST_CONV] = 1'b1;
    end
    set_vec[ST_SUM]   = set_vec[ST_CONV] || set_vec[ST_DUAL] || (short_evt_q && (short_cond_q != 12'h000));
    set_vec[ST_HELD]  = set_vec[ST_SUM];
    cond_vec[ST_SUM]  = cond_vec[ST_CONV] || cond_vec[ST_DUAL] || (cond_vec[17:6] != 12'h000);
    cond_vec[ST_HELD] = cond_vec[ST_SUM];
  end

  // Sticky status flags; set wins over clear
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      err_q <= '0;
    else if (clr_w)
      err_q <= cond_vec | set_vec;
    else
      err_q <= err_q | set_vec;
  end

  // Angle output advances at captured speed while inputs are open
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      speed_hold <= '0;
      angle_q    <= '0;
      monitor_q  <= 1'b0;
      sw_q       <= 1'b0;
    end
    else
    begin
      if (sh.start)
        speed_hold <= speed_i;
      if (sh.sw_open)
        angle_q <= angle_q + speed_hold;
      else
        angle_q <= path_a;
      monitor_q <= sh.sw_open;
      sw_q      <= sh.sw_open;
    end
  end

  assign err_summary_o       = err_q[ST_SUM];
  assign held_fault_o        = err_q[ST_HELD];
  assign switch_open_o       = sw_q;
  assign monitor_at_common_o = monitor_q;
  assign short_test_busy_o   = sw_q;
  assign angle_o             = angle_q;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  arm_mask_time_a: assert property ($rose(mask_released) |->
    arm && $past(arm_cnt) == 24'(ARM_CYCLES - 1))
    else $error("mask released at wrong time");

  arm_mask_early_a: assert property ($rose(arm) |-> !mask_released [*8])
    else $error("mask released too early");

  clear_action_a: assert property ((clr_w && set_vec == '0) |=> err_q == $past(cond_vec))
    else $error("clear left wrong flags");

  conv_route_a: assert property ((conv_evt_q && !cfg[CF_CVROUTE]) |=> err_q[3:0] == 4'hf)
    else $error("conversion fault not routed");

  conv_window_a: assert property (conv_evt_q |-> conv_cond_q && $past(win_end))
    else $error("conversion fault outside window end");

  dual_thr_a: assert property ((!cfg[CF_MODE] && cfg[CF_THR +: 2] == 2'h2 &&
    (abs_diff == ANGLE_W'(32) || abs_diff == ANGLE_W'(33))) |=> dual_raw_q == $past(abs_diff == ANGLE_W'(33)))
    else $error("dual path threshold wrong");

  mode1_lsb_a: assert property ((cfg[CF_MODE] && abs_diff <= ANGLE_W'(2)) |=>
    dual_raw_q == $past(abs_diff == ANGLE_W'(2)))
    else $error("mode 1 comparison wrong");

  dual_route_a: assert property ((dual_raw_q && mask_released && !cfg[CF_DPROUTE]) |=>
    err_q[ST_DUAL] && err_q[ST_DUAL_DET] && err_q[ST_SUM] && err_q[ST_HELD])
    else $error("dual path fault not routed");

  sticky_conv_a: assert property ((err_q[ST_CONV] && !clr_w) |=> err_q[ST_CONV])
    else $error("conversion flag dropped");

  exc_mask_a: assert property ((sh.done && cfg[CF_EXSRC]) |=>
    short_cond_q[1:0] == 2'h0 && short_cond_q[7:6] == 2'h0)
    else $error("excitation line short with internal excitation");

  monitor_common_a: assert property (sh.sw_open |=> monitor_q && switch_open_o)
    else $error("monitor not at common while open");

  angle_hold_a: assert property (sh.sw_open |=>
    angle_q == ANGLE_W'($past(angle_q) + $past(speed_hold)))
    else $error("angle not advancing at held speed");

  conv_fault_c: cover property (conv_evt_q);
  dual_fault_c: cover property (set_vec[ST_DUAL]);
  short_fault_c: cover property (short_evt_q && short_cond_q != 12'h000);
  clear_persist_c: cover property (clr_w && cond_vec != '0);
endmodule
`default_nettype wire

/* File: sim/rcfm_resolver_model.sv */
// Resolver sensor model: rotor angles, epsilon level, half ticks, line levels
`timescale 1ns/1ps
`default_nettype none
module rcfm_resolver_model
#(
  parameter int HALF = 20
)
(
  input  wire logic        clk_sys_i,
  input  wire logic        eps_bad_i,
  input  wire logic [15:0] off0_i,
  input  wire logic [15:0] off1_i,
  input  wire logic [5:0]  sup_i,
  output logic             tick_o,
  output logic             eps_o,
  output logic [15:0]      ang0_o,
  output logic [15:0]      ang1a_o,
  output logic [15:0]      ang1b_o,
  output logic [15:0]      speed_o,
  output logic [5:0]       sup_o
);
  logic [15:0] base = 16'h0000;
  int          cnt  = 0;
  // Rotor turns at a fixed rate and wraps often; excitation halves are fixed
  always @(posedge clk_sys_i)
  begin
    base <= base + speed_o;
    cnt  <= (cnt == HALF - 1) ? 0 : cnt + 1;
  end
  // Path offsets and line shorts come from the scenario
  assign speed_o = 16'h0010;
  assign tick_o  = (cnt == 0);
  assign eps_o   = eps_bad_i;
  assign ang0_o  = base + off0_i;
  assign ang1a_o = base;
  assign ang1b_o = base + off1_i;
  assign sup_o   = sup_i;
endmodule
`default_nettype wire

/* File: sim/resolver_conversion_fault_monitor_test.sv */
// Self-checking bench of the resolver conversion fault monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", n, e, s); end end
module resolver_conversion_fault_monitor_test;
  import rcfm_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wdat      = 32'h0;
  logic        eps_bad   = 1'b0;
  logic [15:0] off0      = 16'h0;
  logic [15:0] off1      = 16'h0;
  logic [5:0]  sup       = 6'h00;
  logic [5:0]  gnd       = 6'h00;
  logic [3:0]  be        = 4'hf;
  logic        eps_std   = 1'b0;
  logic [31:0] rdat, q;
  logic        wreq, tick, eps, sum, held, sw, mon, busy;
  logic [15:0] a0, a1a, a1b, spd, ang, last;
  logic [5:0]  lsup;
  int          miscompares = 0;
  int          compares    = 0;
  // Clock
  always #2 clk_sys_i = ~clk_sys_i;
  rcfm_resolver_model i_res (.clk_sys_i(clk_sys_i), .eps_bad_i(eps_bad), .off0_i(off0),
    .off1_i(off1), .sup_i(sup), .tick_o(tick), .eps_o(eps), .ang0_o(a0), .ang1a_o(a1a),
    .ang1b_o(a1b), .speed_o(spd), .sup_o(lsup));
  rcfm_monitor_top #(.ARM_CYCLES(50), .JUDGE_CYC0(200), .JUDGE_CYC1(250), .JUDGE_CYC2(300),
    .JUDGE_CYC3(400)) i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .epsilon_out_of_range_hs_i(eps),
    .epsilon_out_of_range_std_i(eps_std), .exc_half_tick_i(tick), .angle_mode0_i(a0),
    .angle_mode1_a_i(a1a), .angle_mode1_b_i(a1b), .speed_i(spd), .line_at_supply_i(lsup),
    .line_at_ground_i(gnd), .err_summary_o(sum), .held_fault_o(held), .switch_open_o(sw),
    .monitor_at_common_o(mon), .short_test_busy_o(busy), .angle_o(ang));
  // One Avalon access; holds the request until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic st;
    int   n;
    st = 1'b1;
    n = 0;
    @(posedge clk_sys_i);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    while (st !== 1'b0 && n < 50)
    begin
      @(posedge clk_sys_i);
      st = wreq;
      q = rdat;
      n++;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
      miscompares++;
  endtask
  // Set path offsets, let them settle, compare the status word
  task automatic probe(input logic [15:0] o0, o1, input logic [31:0] e, input string nm);
    off0 <= o0;
    off1 <= o1;
    repeat (10) @(posedge clk_sys_i);
    acc(1'b0, REG_STAT, 32'h0);
    `CHK(nm, e, q)
    `CHK("sum held pins", e[1:0], {held, sum})
  endtask
  // Clear action with the arm bit kept set
  task automatic clear;
    acc(1'b1, REG_CTRL, 32'h3);
    acc(1'b0, REG_STAT, 32'h0);
  endtask
  // Reset values and an unmapped place
  task automatic t_regs;
    acc(1'b1, 8'h20, 32'h7ff);
    acc(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, q)
    acc(1'b0, REG_CFG, 32'h0);
    `CHK("cfg reset", 32'h0, q)
    be <= 4'h2;
    acc(1'b1, REG_CFG, 32'h7ff);
    be <= 4'hf;
    acc(1'b0, REG_CFG, 32'h0);
    `CHK("lane one only", 32'h700, q)
    acc(1'b1, REG_CFG, 32'h0);
    $display("test regs done");
  endtask
  // Faults stay hidden until the arm delay has run out
  task automatic t_arm;
    probe(16'd33, 16'd0, 32'h0, "before arm");
    acc(1'b1, REG_CTRL, 32'h1);
    repeat (38) @(posedge clk_sys_i);
    acc(1'b0, REG_STAT, 32'h0);
    `CHK("masked", 32'h0, q)
    repeat (20) @(posedge clk_sys_i);
    acc(1'b0, REG_CTRL, 32'h0);
    `CHK("released", 1'b1, q[1])
    probe(16'd33, 16'd0, 32'h33, "after arm");
    off0 <= 16'd0;
    repeat (5) @(posedge clk_sys_i);
    clear;
    `CHK("cleared", 32'h0, q)
    $display("test arm done");
  endtask
  // Mode 0 threshold code 2, wrap, stickiness, clear
  task automatic t_dual;
    acc(1'b1, REG_CFG, 32'h40);
    probe(16'hffe0, 16'd0, 32'h0, "minus 32");
    probe(16'd32, 16'd0, 32'h0, "plus 32");
    probe(16'd33, 16'd0, 32'h33, "plus 33");
    probe(16'd0, 16'd0, 32'h33, "sticky");
    clear;
    `CHK("dual cleared", 32'h0, q)
    $display("test dual done");
  endtask
  // Mode 1 twin circuits at one LSB; clear while the fault persists
  task automatic t_mode1;
    acc(1'b1, REG_CFG, 32'h50);
    probe(16'd100, 16'd1, 32'h0, "mode1 one");
    probe(16'd0, 16'd2, 32'h33, "mode1 two");
    clear;
    `CHK("persist", 32'h33, q)
    probe(16'd0, 16'd0, 32'h33, "mode1 sticky");
    clear;
    `CHK("mode1 cleared", 32'h0, q)
    $display("test mode1 done");
  endtask
  // Epsilon out of range on every half; longest window code; detector choice
  task automatic t_conv;
    acc(1'b1, REG_CFG, 32'h07);
    eps_bad <= 1'b1;
    repeat (900) @(posedge clk_sys_i);
    acc(1'b0, REG_STAT, 32'h0);
    `CHK("std quiet", 4'h0, q[3:0])
    acc(1'b1, REG_CFG, 32'h06);
    repeat (900) @(posedge clk_sys_i);
    acc(1'b0, REG_STAT, 32'h0);
    `CHK("conv flags", 4'hf, q[3:0])
    eps_bad <= 1'b0;
    eps_std <= 1'b1;
    repeat (900) @(posedge clk_sys_i);
    acc(1'b0, REG_STAT, 32'h0);
    `CHK("conv sticky", 1'b1, q[ST_CONV])
    clear;
    `CHK("conv cleared", 32'h0, q)
    eps_std <= 1'b0;
    $display("test conv done");
  endtask
  // One software-started short sequence; expected supply and ground flags
  task automatic short_run(input logic [31:0] c, input logic [5:0] ep, eg);
    int n;
    n = 0;
    acc(1'b1, REG_CFG, c);
    acc(1'b1, REG_CTRL, 32'h5);
    for (int i = 0; i < 21000; i++)
    begin
      @(negedge clk_sys_i);
      if (sw === 1'b1)
        n++;
      if (n == 100)
        `CHK("angle step", last + spd, ang)
      if (n == 100)
        `CHK("monitor common", 1'b1, mon)
      if (n == 100)
        `CHK("busy", 1'b1, busy)
      last = ang;
    end
    `CHK("open cycles", 6 * SLOT_CYC, n)
    acc(1'b0, REG_STAT, 32'h0);
    `CHK("supply lines", ep, q[ST_PWR +: 6])
    `CHK("ground lines", eg, q[ST_GND +: 6])
    `CHK("short conv", 1'b1, q[ST_CONV])
  endtask
  // Internal excitation hides lines 0 and 1, external excitation shows them
  task automatic t_short;
    sup <= 6'b001001;
    gnd <= 6'b100010;
    short_run(32'h300, 6'b001000, 6'b100000);
    short_run(32'h200, 6'b001001, 6'b100010);
    $display("test short done");
  endtask
  // Counts and verdict
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    t_regs;
    t_arm;
    t_dual;
    t_mode1;
    t_conv;
    t_short;
    final_report;
  end
  // Watchdog
  initial
  begin
    #300000;
    miscompares++;
    final_report;
  end
endmodule
`default_nettype wire
